// file: hdl/timer_counter_core.sv
// One timer: clock selection, prescaler, counter with coherent byte reads, shared pins.
// Operation
// - each channel uses one pin shared with a general-purpose port pin.
// - route bit feeds comparator into channel 0 capture, channel 0 pin unavailable.
// - clock source select 1:1 picks the external timer clock pin.
// - the one external clock pin may clock both timers and modulo timer together.
// - an unbonded second channel still runs internally as a software compare.
// - any write to either counter byte clears counter and prescaler.
// - in background debug mode counter reads return the frozen current counter.
// - in debug mode writes to status/control or counter bytes clear the latch.
`timescale 1ns/1ps
`default_nettype none
`include "timer_counter_defs.svh"
module timer_counter_core #(
   parameter int unsigned CHANS      = `CHAN_COUNT,
   parameter bit          CH1_BONDED = 1'b1
) (
   input  wire logic                          clock_i,
   input  wire logic                          rst_i,
   input  wire timer_counter_pkg::timer_ctrl_t ctrl_i,
   input  wire timer_counter_pkg::count_access_t access_i,
   input  wire logic                          background_debug_mode_i,
   input  wire logic                          comparator_to_capture_route_i,
   input  wire logic                          analog_comparator_i,
   input  wire logic                          external_timer_clock_pin_i,
   input  wire logic                          fixed_tick_i,
   input  wire logic [CHANS-1:0]              chan_enable_i,
   input  wire logic [CHANS-1:0]              chan_compare_mode_i,
   input  wire logic [CHANS*`COUNT_W-1:0]     chan_value_i,
   input  wire timer_counter_pkg::pin_drive_t [CHANS-1:0] gpio_i,
   input  wire logic [CHANS-1:0]              timer_channel_pin_i,
   output var  timer_counter_pkg::pin_drive_t [CHANS-1:0] timer_channel_pin_o,
   output logic [CHANS-1:0]                   chan_event_o,
   output logic [CHANS*`COUNT_W-1:0]          chan_capture_o,
   output logic [`COUNT_W-1:0]                count_o,
   output logic [7:0]                         read_data_o,
   output logic                               external_timer_clock_o
);
   import timer_counter_pkg::*;

   // =============================================================
   // State
   logic [`COUNT_W-1:0]        count_ff,   nxt_count;
   logic [`PRESCALE_CNT_W-1:0] presc_ff,   nxt_presc;
   logic [`COUNT_W-1:0]        latch_ff,   nxt_latch;
   logic                       latch_v_ff, nxt_latch_v;
   logic [7:0]                 rdata_ff,   nxt_rdata;
   logic                       ext_prev_ff;
   logic                       ext_tick_ff;
   logic                       src_tick;
   logic                       count_tick;
   logic                       cnt_write;
   logic [`PRESCALE_CNT_W-1:0] presc_mask;

   // =============================================================
   // External clock edge, offered to every timer and the modulo timer.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ext_prev_ff <= 1'b0;
         ext_tick_ff <= 1'b0;
      end else begin
         ext_prev_ff <= external_timer_clock_pin_i;
         ext_tick_ff <= external_timer_clock_pin_i & ~ext_prev_ff;
      end
   end
   assign external_timer_clock_o = ext_tick_ff;

   // =============================================================
   // Counter, prescaler and coherency latch next values.
   // The counter holds while debug is active unless a counter byte is written, so debug reads see one stable value.
   always_comb begin
      cnt_write  = access_i.wr_high | access_i.wr_low;
      presc_mask = `PRESCALE_CNT_W'((1 << ctrl_i.prescale) - 1);
      case (ctrl_i.clock_source_select)
         `CLK_SRC_OFF:   src_tick = 1'b0;
         `CLK_SRC_BUS:   src_tick = 1'b1;
         `CLK_SRC_FIXED: src_tick = fixed_tick_i;
         `CLK_SRC_EXT:   src_tick = ext_tick_ff;
         default:        src_tick = 1'b0;
      endcase
      src_tick   = src_tick & ~background_debug_mode_i;
      count_tick = src_tick && ((presc_ff & presc_mask) == presc_mask);
      nxt_presc  = src_tick ? presc_ff + `PRESCALE_CNT_W'(1) : presc_ff;
      nxt_count  = count_tick ? count_ff + `COUNT_W'(1) : count_ff;
      if (cnt_write) begin
         nxt_presc = `PRESCALE_RESET;
         nxt_count = `COUNT_RESET;
      end
      nxt_latch   = latch_ff;
      nxt_latch_v = latch_v_ff;
      nxt_rdata   = rdata_ff;
      if (background_debug_mode_i) begin
         if (access_i.rd_high) nxt_rdata = count_ff[15:8];
         if (access_i.rd_low)  nxt_rdata = count_ff[7:0];
         if (cnt_write || access_i.wr_status_control) begin
            nxt_latch_v = 1'b0;
         end
      end else if (access_i.rd_high || access_i.rd_low) begin
         // A second read takes the held byte; a first read snapshots both halves.
         if (latch_v_ff) begin
            nxt_rdata   = access_i.rd_high ? latch_ff[15:8] : latch_ff[7:0];
            nxt_latch_v = 1'b0;
         end else begin
            nxt_rdata   = access_i.rd_high ? count_ff[15:8] : count_ff[7:0];
            nxt_latch   = count_ff;
            nxt_latch_v = 1'b1;
         end
      end else if (cnt_write) begin
         nxt_latch_v = 1'b0;
      end
   end

   // Registering of the counter group.
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         count_ff   <= `COUNT_RESET;
         presc_ff   <= `PRESCALE_RESET;
         latch_ff   <= `COUNT_RESET;
         latch_v_ff <= 1'b0;
         rdata_ff   <= `BYTE_RESET;
      end else begin
         count_ff   <= nxt_count;
         presc_ff   <= nxt_presc;
         latch_ff   <= nxt_latch;
         latch_v_ff <= nxt_latch_v;
         rdata_ff   <= nxt_rdata;
      end
   end
   assign count_o     = count_ff;
   assign read_data_o = rdata_ff;

   // =============================================================
   // Channels: pin sharing, capture and compare, one copy per channel.
   for (genvar ch = 0; ch < CHANS; ch++) begin : g_chan
      logic             routed;
      logic             bonded;
      logic             cap_in;
      logic             cap_prev_ff, nxt_cap_prev;
      logic             evt_ff,      nxt_evt;
      logic             cmp_out_ff,  nxt_cmp_out;
      logic [`COUNT_W-1:0] cap_ff,   nxt_cap;
      pin_drive_t       pin_ff,      nxt_pin;

      assign routed = (ch == 0) && comparator_to_capture_route_i;
      assign bonded = (ch != 1) || CH1_BONDED;

      // The comparator replaces the pin, so a floating pin cannot disturb capture.
      always_comb begin
         cap_in       = routed ? analog_comparator_i : timer_channel_pin_i[ch];
         nxt_cap_prev = cap_in;
         nxt_evt      = 1'b0;
         nxt_cap      = cap_ff;
         nxt_cmp_out  = cmp_out_ff;
         if (chan_enable_i[ch] || routed) begin
            if (chan_compare_mode_i[ch] && !routed) begin
               // Compare runs whether or not the pin is bonded out.
               if (count_tick && nxt_count == chan_value_i[ch*`COUNT_W +: `COUNT_W]) begin
                  nxt_evt     = 1'b1;
                  nxt_cmp_out = ~cmp_out_ff;
               end
            end else if (cap_in && !cap_prev_ff) begin
               nxt_evt = 1'b1;
               nxt_cap = count_ff;
            end
         end
         if (routed || !bonded) begin
            nxt_pin = '{out: 1'b0, oe: 1'b0};
         end else if (chan_enable_i[ch]) begin
            nxt_pin = '{out: cmp_out_ff, oe: chan_compare_mode_i[ch]};
         end else begin
            nxt_pin = gpio_i[ch];
         end
      end

      // Registering of the channel group.
      always_ff @(posedge clock_i or posedge rst_i) begin
         if (rst_i) begin
            cap_prev_ff <= 1'b0;
            evt_ff      <= 1'b0;
            cmp_out_ff  <= 1'b0;
            cap_ff      <= `COUNT_RESET;
            pin_ff      <= '{out: 1'b0, oe: 1'b0};
         end else begin
            cap_prev_ff <= nxt_cap_prev;
            evt_ff      <= nxt_evt;
            cmp_out_ff  <= nxt_cmp_out;
            cap_ff      <= nxt_cap;
            pin_ff      <= nxt_pin;
         end
      end
      assign timer_channel_pin_o[ch]                   = pin_ff;
      assign chan_event_o[ch]                          = evt_ff;
      assign chan_capture_o[ch*`COUNT_W +: `COUNT_W]   = cap_ff;
   end

   // =============================================================
   // Checks.
   sequence s_first_read;
      !background_debug_mode_i && (access_i.rd_high || access_i.rd_low) && !latch_v_ff;
   endsequence
   // A read outside debug with the latch full must hand back the held byte, whatever came in between.
   sequence s_other_read;
      !background_debug_mode_i && latch_v_ff && (access_i.rd_high || access_i.rd_low);
   endsequence

   a_write_clears_count: assert property (@(posedge clock_i) disable iff (rst_i)
      (access_i.wr_high || access_i.wr_low) |=> (count_ff == `COUNT_RESET))
      else $error("Counter write did not clear the counter.");
   a_write_clears_presc: assert property (@(posedge clock_i) disable iff (rst_i)
      (access_i.wr_high || access_i.wr_low) |=> (presc_ff == `PRESCALE_RESET))
      else $error("Counter write did not clear the prescaler.");
   a_debug_count_frozen: assert property (@(posedge clock_i) disable iff (rst_i)
      background_debug_mode_i && !access_i.wr_high && !access_i.wr_low
      |=> count_ff == $past(count_ff))
      else $error("Counter moved during debug mode.");
   a_debug_read_live: assert property (@(posedge clock_i) disable iff (rst_i)
      background_debug_mode_i && access_i.rd_high |=> rdata_ff == count_ff[15:8])
      else $error("Debug read did not return the live counter.");
   a_debug_write_clear: assert property (@(posedge clock_i) disable iff (rst_i)
      background_debug_mode_i && access_i.wr_status_control |=> !latch_v_ff)
      else $error("Debug write left the coherency latch set.");
   a_coherent_read_pair: assert property (@(posedge clock_i) disable iff (rst_i)
      s_other_read |=> rdata_ff == ($past(access_i.rd_high) ? $past(latch_ff[15:8])
      : $past(latch_ff[7:0])))
      else $error("Second counter byte not coherent with the first.");
   a_first_read_latches: assert property (@(posedge clock_i) disable iff (rst_i)
      s_first_read |=> latch_v_ff && latch_ff == $past(count_ff))
      else $error("First counter read did not latch the counter.");
   a_ext_select_counts: assert property (@(posedge clock_i) disable iff (rst_i)
      ctrl_i.clock_source_select == `CLK_SRC_EXT && !ext_tick_ff |-> !src_tick)
      else $error("External source advanced without a pin edge.");
   a_route_pin_off: assert property (@(posedge clock_i) disable iff (rst_i)
      comparator_to_capture_route_i [*2] |-> !timer_channel_pin_o[0].oe)
      else $error("Routed channel 0 pin still driven.");
   a_ext_tick_shared: assert property (@(posedge clock_i) disable iff (rst_i)
      external_timer_clock_pin_i && !ext_prev_ff |=> external_timer_clock_o)
      else $error("External clock edge not offered to other timers.");

endmodule : timer_counter_core
`default_nettype wire

// file: hdl/timer_counter_defs.svh
// Constants for the timer counter: clock source codes, widths and reset values.
`ifndef TIMER_COUNTER_DEFS_SVH
`define TIMER_COUNTER_DEFS_SVH

// =============================================================
// Clock source select codes
`define CLK_SRC_OFF       2'h0
`define CLK_SRC_BUS       2'h1
`define CLK_SRC_FIXED     2'h2
`define CLK_SRC_EXT       2'h3

// =============================================================
// Widths and reset values
`define COUNT_W           16
`define PRESCALE_W        3
`define PRESCALE_CNT_W    7
`define COUNT_RESET       16'h0000
`define PRESCALE_RESET    7'h00
`define BYTE_RESET        8'h00
`define CHAN_COUNT        2

`endif

// file: hdl/timer_counter_pkg.sv
// Types shared by the timer counter and its surroundings.
`include "timer_counter_defs.svh"
package timer_counter_pkg;

   // =============================================================
   // Timer control as one carrier.
   typedef struct packed {
      logic [1:0]               clock_source_select;
      logic [`PRESCALE_W-1:0]   prescale;
   } timer_ctrl_t;

   // =============================================================
   // One pin as its driven level and output enable.
   typedef struct packed {
      logic out;
      logic oe;
   } pin_drive_t;

   // Byte access strobes on the counter.
   typedef struct packed {
      logic rd_high;
      logic rd_low;
      logic wr_high;
      logic wr_low;
      logic wr_status_control;
   } count_access_t;

endpackage : timer_counter_pkg

// file: testbench/timer_counter_clock_and_access_tb.sv
// Self-checking bench for the timer counter core.
`timescale 1ns/1ps
`default_nettype none
`include "timer_counter_defs.svh"
module timer_counter_clock_and_access_tb;
   import timer_counter_pkg::*;
   // ==============================================================
   // Stimulus, observation and bookkeeping
   logic             clock_i = 1'b0;
   logic             rst_i = 1'b1;
   timer_ctrl_t      ctrl = '0;
   count_access_t    acc = '0;
   logic             dbg = 1'b0;
   logic             route = 1'b0;
   logic             analog_comparator = 1'b0;
   logic             ext = 1'b0;
   logic             fix = 1'b0;
   logic [1:0]       ch_en = 2'h0;
   logic [1:0]       ch_cmp = 2'h0;
   logic [31:0]      ch_val = 32'h0;
   pin_drive_t [1:0] gpio = '0;
   logic [1:0]       pin_in = 2'h0;
   pin_drive_t [1:0] pin_o;
   logic [1:0]       ev;
   logic [31:0]      cap;
   logic [15:0]      count_o;
   logic [7:0]       rdata;
   logic             ext_o;
   logic [15:0]      ref_cnt = 16'h0;
   logic [15:0]      rnd = 16'h9B92;
   logic [15:0]      snap;
   logic [7:0]       hi, lo, lo2;
   int               fail_count = 0, checks = 0, ev0 = 0, ev1 = 0, ext_cnt = 0;

   // Clock at 40 MHz.
   always #12.5 clock_i = ~clock_i;

   // Channel 1 is left unbonded so its internal compare can be seen without a pin.
   timer_counter_core #(.CHANS(2), .CH1_BONDED(1'b0)) uut (
      .clock_i(clock_i), .rst_i(rst_i), .ctrl_i(ctrl), .access_i(acc),
      .background_debug_mode_i(dbg), .comparator_to_capture_route_i(route),
      .analog_comparator_i(analog_comparator), .external_timer_clock_pin_i(ext), .fixed_tick_i(fix),
      .chan_enable_i(ch_en), .chan_compare_mode_i(ch_cmp), .chan_value_i(ch_val),
      .gpio_i(gpio), .timer_channel_pin_i(pin_in), .timer_channel_pin_o(pin_o),
      .chan_event_o(ev), .chan_capture_o(cap), .count_o(count_o), .read_data_o(rdata),
      .external_timer_clock_o(ext_o));

   // Reference count of bus-clock cycles since the last counter write; frozen in debug.
   always @(posedge clock_i) begin
      if (acc.wr_high || acc.wr_low) ref_cnt <= 16'h0000;
      else if (ctrl.clock_source_select == `CLK_SRC_BUS && !dbg) ref_cnt <= ref_cnt + 16'h0001;
      if (ev[0] === 1'b1) ev0 <= ev0 + 1;
      if (ev[1] === 1'b1) ev1 <= ev1 + 1;
      if (ext_o === 1'b1) ext_cnt <= ext_cnt + 1;
   end

   // ==============================================================
   // Helpers
   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction : lfsr

   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask : cyc

   // One-cycle strobe: bit 4 is rd_high, down to bit 0 for status/control.
   task automatic strobe(input int k);
      acc = count_access_t'(5'h01 << k);
      cyc(1);
      acc = '0;
   endtask : strobe

   task automatic rd(input int k, output logic [7:0] b);
      strobe(k);
      cyc(1);
      b = rdata;
   endtask : rd

   // Tolerance absorbs the one or two cycles of latency between bench model and counter.
   task automatic check16(input string nm, input logic [15:0] exp, input logic [15:0] seen,
                          input logic [15:0] tol);
      logic [15:0] d;
      d = seen - exp;
      checks++;
      if (((d <= tol) || ((16'h0000 - d) <= tol)) !== 1'b1) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check16

   task automatic stop_test();
      $display("fail_count %0d checks %0d", fail_count, checks);
      if (fail_count == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test

   // ==============================================================
   // Scenarios
   initial begin
      int n;
      int e;
      cyc(12);
      rst_i = 1'b0;
      cyc(1);
      check16("count_reset", 16'h0000, count_o, 16'h0000);
      for (int p = 0; p < 4; p++) begin
         ctrl = '{clock_source_select: `CLK_SRC_BUS, prescale: 3'(p)};
         strobe(p[0] ? 2 : 1);
         rnd = lfsr(rnd);
         cyc(40 + int'(rnd[5:0]));
         check16("count_tick", ref_cnt >> p, count_o, 16'h0002);
      end
      ctrl.clock_source_select = `CLK_SRC_OFF;
      strobe(1);
      cyc(2);
      check16("count_clear", 16'h0000, count_o, 16'h0000);
      ctrl = '{clock_source_select: `CLK_SRC_BUS, prescale: 3'h0};
      cyc(20);
      snap = ref_cnt;
      rd(3, lo);
      cyc(300);
      rd(4, hi);
      check16("coherent_pair", snap, {hi, lo}, 16'h0002);
      dbg = 1'b1;
      cyc(2);
      snap = ref_cnt;
      rd(4, hi);
      cyc(30);
      rd(3, lo);
      rd(3, lo2);
      check16("frozen_read", snap, {hi, lo}, 16'h0002);
      check16("frozen_again", {8'h00, lo}, {8'h00, lo2}, 16'h0000);
      check16("frozen_count", {hi, lo}, count_o, 16'h0000);
      dbg = 1'b0;
      rd(4, hi);
      dbg = 1'b1;
      strobe(0);
      dbg = 1'b0;
      cyc(300);
      snap = ref_cnt;
      rd(3, lo);
      check16("latch_cleared", {snap[7:0], 8'h00}, {lo, 8'h00}, 16'h0200);
      ctrl = '{clock_source_select: `CLK_SRC_EXT, prescale: 3'h0};
      strobe(2);
      rnd = lfsr(rnd);
      n = 3 + int'(rnd[2:0]);
      e = ext_cnt;
      repeat (n) begin
         ext = 1'b1;
         cyc(2);
         ext = 1'b0;
         cyc(2);
      end
      cyc(3);
      check16("ext_pulses", 16'(n), 16'(ext_cnt - e), 16'h0000);
      check16("ext_count", 16'(n), count_o, 16'h0000);
      // The fixed tick source must count its own ticks; the count then stays put.
      ctrl.clock_source_select = `CLK_SRC_FIXED;
      strobe(2);
      repeat (n) begin
         fix = 1'b1;
         cyc(1);
         fix = 1'b0;
         cyc(2);
      end
      check16("fixed_count", 16'(n), count_o, 16'h0000);
      // Channel 1 is unbonded here, so only channel 0 passes the port drive through.
      repeat (4) begin
         rnd = lfsr(rnd);
         gpio = rnd[3:0];
         cyc(3);
         check16("gpio_pass", {14'h0000, rnd[1:0]}, {12'h000, pin_o}, 16'h0000);
      end
      route = 1'b1;
      ch_en = 2'h3;
      cyc(3);
      check16("routed_pin", 16'h0000, {14'h0000, pin_o[0]}, 16'h0000);
      e = ev0;
      analog_comparator = 1'b1;
      cyc(4);
      analog_comparator = 1'b0;
      cyc(4);
      check16("route_event", 16'h0001, {15'h0000, ev0 != e}, 16'h0000);
      check16("route_capture", 16'(n), cap[15:0], 16'h0000);
      e = ev0;
      pin_in[0] = 1'b1;
      cyc(4);
      pin_in[0] = 1'b0;
      cyc(4);
      check16("pin_ignored", 16'h0000, 16'(ev0 - e), 16'h0000);
      route = 1'b0;
      ch_cmp = 2'h3;
      rnd = lfsr(rnd);
      ch_val = {16'h0020 | {11'h000, rnd[4:0]}, 16'h0030};
      ctrl = '{clock_source_select: `CLK_SRC_BUS, prescale: 3'h0};
      strobe(1);
      e = ev1;
      cyc(100);
      check16("unbonded_cmp", 16'h0001, {15'h0000, ev1 != e}, 16'h0000);
      check16("unbonded_pin", 16'h0000, {14'h0000, pin_o[1]}, 16'h0000);
      check16("owned_pin_oe", 16'h0001, {15'h0000, pin_o[0].oe}, 16'h0000);
      stop_test();
   end

   // Watchdog well beyond the roughly eleven hundred cycles the scenarios need.
   initial begin
      #(25 * 20000);
      fail_count++;
      stop_test();
   end
endmodule : timer_counter_clock_and_access_tb
`default_nettype wire
